// File: logic/loop_timer_pkg.sv
// Purpose: Shared constants and types for the loop timer PWM engine
// Assumes: APB register access, one 200 MHz clock
// Notes: Instruction words live in two 32-bit halves, control and data
package loop_timer_pkg;
    // APB register byte offsets
    localparam int APB_AW = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PRESCALE = 8'h04;
    localparam logic [7:0] OFF_RAM_ADDR = 8'h08;
    localparam logic [7:0] OFF_RAM_CTRL = 8'h0c;
    localparam logic [7:0] OFF_RAM_DATA = 8'h10;
    localparam logic [7:0] OFF_PINS = 8'h14;
    localparam logic [7:0] OFF_REG_A = 8'h18;
    localparam logic [7:0] OFF_REG_B = 8'h1c;
    // Control and prescale register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int PRESCALE_HR_LSB = 0;
    localparam int PRESCALE_LR_LSB = 8;
    localparam int CODE_W = 3;
    localparam logic [2:0] RESET_HR_CODE = 3'h0;
    localparam logic [2:0] RESET_LR_CODE = 3'h3;
    localparam logic [2:0] MAX_CODE = 3'h7;
    // Program memory geometry
    localparam int RAM_DEPTH = 16;
    localparam int RAM_AW = 4;
    // Instruction control word fields
    localparam int NEXT_LSB = 0;
    localparam int OPC_LSB = 4;
    localparam int REGSEL_BIT = 6;
    localparam int PIN_EN_BIT = 7;
    localparam int HIRES_BIT = 8;
    localparam int ORDER_BIT = 9;
    localparam int ACTION_BIT = 10;
    localparam int PIN_LSB = 11;
    localparam int PIN_W = 5;
    localparam int CEIL_LSB = 16;
    localparam int CEIL_W = 16;
    // Compare word and count field layout
    localparam int HIRES_DELAY_W = 7;
    localparam int LOOP_DATA_LSB = 7;
    localparam int LOOP_DATA_W = 25;
    localparam int COUNT_W = 25;
    localparam int SLOT_W = 15;
    // Instruction kinds
    typedef enum logic [1:0] {
        NO_OP = 2'h0,
        VIRTUAL_COUNT_OP = 2'h1,
        MAGNITUDE_COMPARE_OP = 2'h2
    } opcode_type;
    // Engine sequencing states, one-hot
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_RUN = 2'b10
    } engine_state_type;
endpackage

// File: logic/pin_edge_if.sv
// Purpose: Carries pin edge requests from the engine to the pin unit
// Assumes: Requests are one-cycle pulses on the system clock
// Notes: Pin levels flow back to the engine for readback
`timescale 1ns/1ps
`default_nettype none
interface pin_edge_if #(parameter int PINS = 8);
    logic hr_tick; // High-resolution period tick
    logic arm_req; // Schedule a delayed edge
    logic [loop_timer_pkg::PIN_W-1:0] arm_pin;
    logic arm_level;
    logic [loop_timer_pkg::HIRES_DELAY_W-1:0] arm_delay;
    logic clr_req; // Immediate level change
    logic [loop_timer_pkg::PIN_W-1:0] clr_pin;
    logic clr_level;
    logic [PINS-1:0] pins; // Current pin levels
    modport engine (output hr_tick, arm_req, arm_pin, arm_level, arm_delay,
        output clr_req, clr_pin, clr_level, input pins);
    modport unit (input hr_tick, arm_req, arm_pin, arm_level, arm_delay,
        input clr_req, clr_pin, clr_level, output pins);
endinterface
`default_nettype wire

// File: logic/pin_edge_unit.sv
// Purpose: Per-pin edge placement counters with sub-loop delay
// Assumes: One arm request per pin per loop at most
// Notes: A new arm replaces any edge still pending on that pin
`timescale 1ns/1ps
`default_nettype none
module pin_edge_unit #(
    parameter int PINS = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    pin_edge_if.unit pe
);
    logic [PINS-1:0] level_q, level_d; // Driven pin levels
    logic [PINS-1:0] pend_q, pend_d; // Edge waiting on its delay
    logic [PINS-1:0] goal_q, goal_d; // Level the pending edge applies
    logic [loop_timer_pkg::HIRES_DELAY_W-1:0] cnt_q [PINS]; // Ticks left
    logic [loop_timer_pkg::HIRES_DELAY_W-1:0] cnt_d [PINS];

    // Next pin state; arm after clear so a same-cycle match still lands
    always_comb begin
        level_d = level_q;
        pend_d = pend_q;
        goal_d = goal_q;
        cnt_d = cnt_q;
        for (int i = 0; i < PINS; i++) begin
            if (pend_q[i] && cnt_q[i] == '0) begin
                level_d[i] = goal_q[i];
                pend_d[i] = 1'b0;
            end else if (pend_q[i] && pe.hr_tick) begin
                // Counts in high-resolution periods, full rate when ratio is one
                cnt_d[i] = cnt_q[i] - 7'h01;
            end
            if (pe.clr_req && pe.clr_pin == loop_timer_pkg::PIN_W'(i)) begin
                level_d[i] = pe.clr_level;
            end
            if (pe.arm_req && pe.arm_pin == loop_timer_pkg::PIN_W'(i)) begin
                pend_d[i] = 1'b1;
                goal_d[i] = pe.arm_level;
                cnt_d[i] = pe.arm_delay;
            end
        end
    end

    // Register pin state
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            level_q <= '0;
            pend_q <= '0;
            goal_q <= '0;
            for (int i = 0; i < PINS; i++) begin
                cnt_q[i] <= '0;
            end
        end else begin
            level_q <= level_d;
            pend_q <= pend_d;
            goal_q <= goal_d;
            cnt_q <= cnt_d;
        end
    end

    assign pe.pins = level_q;

    // Expired delay must land the goal level on pin zero
    a_delay_edge_lands:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (pend_q[0] && cnt_q[0] == '0 && !(pe.arm_req && pe.arm_pin == '0)
            && !(pe.clr_req && pe.clr_pin == '0))
        |=> level_q[0] == $past(goal_q[0]))
    else $error("pending edge did not land after delay");
endmodule
`default_nettype wire

// File: logic/loop_timer_pwm_engine.sv
// Purpose: Loop timer coprocessor running a small PWM program from its RAM
// Assumes: APB slave, no wait states, synchronous active-high reset
// Notes: One instruction per clock from slot zero of each loop period
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module loop_timer_pwm_engine #(
    parameter int PINS = 8,
    parameter int DEPTH = loop_timer_pkg::RAM_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [loop_timer_pkg::APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [PINS-1:0] o_pin_out
);
    localparam int AW = loop_timer_pkg::RAM_AW;
    localparam int CW = loop_timer_pkg::COUNT_W;

    // Ratio from a power-of-two code
    function automatic logic [7:0] ratio_of(input logic [2:0] code);
        return 8'h01 << code;
    endfunction

    // Keep only the delay bits that the loop ratio makes meaningful
    function automatic logic [6:0] valid_delay(input logic [6:0] f, input logic [2:0] lr_code);
        return f >> (loop_timer_pkg::MAX_CODE - lr_code);
    endfunction

    // Software-visible state
    logic run_q, run_d; // Engine enable
    logic [2:0] hr_code_q, hr_code_d; // hires_divide code
    logic [2:0] lr_code_q, lr_code_d; // loop_divide code
    logic [AW-1:0] ram_addr_q, ram_addr_d; // Host program pointer
    logic [31:0] ram_ctrl_q [DEPTH]; // Instruction control words
    logic [31:0] ram_ctrl_d [DEPTH];
    logic [31:0] ram_data_q [DEPTH]; // Instruction data words
    logic [31:0] ram_data_d [DEPTH];
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    // Prescaler state
    logic [7:0] hcnt_q, hcnt_d; // Master clocks within hires_period
    logic [7:0] lcnt_q, lcnt_d; // hires periods within loop_period
    // Engine state
    loop_timer_pkg::engine_state_type state_q, state_d;
    logic [AW-1:0] pc_q, pc_d; // Address of instruction executing
    logic [loop_timer_pkg::SLOT_W-1:0] slot_q, slot_d; // Slots used this loop
    logic [CW-1:0] reg_a_q, reg_a_d;
    logic [CW-1:0] reg_b_q, reg_b_d;
    logic wrap_q, wrap_d; // Counter wrapped in this loop

    // Derived timing and decode
    logic [7:0] hr_ratio, lr_ratio;
    logic [loop_timer_pkg::SLOT_W-1:0] timeslot_count;
    logic hr_tick, loop_start;
    logic [31:0] instr_ctrl, compare_word;
    loop_timer_pkg::opcode_type opc;
    logic [AW-1:0] next_addr;
    logic [CW-1:0] reg_val, cnt_field, count_ceiling, cnt_new;
    logic [loop_timer_pkg::LOOP_DATA_W-1:0] loop_data;
    logic [loop_timer_pkg::HIRES_DELAY_W-1:0] hires_delay_field;
    logic match, exec_count, exec_cmp, eng_we;
    logic pulse_high_action, resolution_select, pin_en;
    logic [loop_timer_pkg::PIN_W-1:0] pin_sel;
    logic apb_setup, apb_write;

    pin_edge_if #(.PINS(PINS)) pe_bus ();

    assign hr_ratio = ratio_of(hr_code_q);
    assign lr_ratio = ratio_of(lr_code_q);
    // Program budget is loop ratio times high-res ratio; overrun is cut
    assign timeslot_count = loop_timer_pkg::SLOT_W'(lr_ratio) *
        loop_timer_pkg::SLOT_W'(hr_ratio);

    // Current instruction fields
    assign instr_ctrl = ram_ctrl_q[pc_q];
    assign compare_word = ram_data_q[pc_q];
    assign opc = loop_timer_pkg::opcode_type'(instr_ctrl[loop_timer_pkg::OPC_LSB +: 2]);
    assign next_addr = instr_ctrl[loop_timer_pkg::NEXT_LSB +: AW];
    assign pin_en = instr_ctrl[loop_timer_pkg::PIN_EN_BIT];
    assign resolution_select = instr_ctrl[loop_timer_pkg::HIRES_BIT];
    assign pulse_high_action = instr_ctrl[loop_timer_pkg::ACTION_BIT];
    assign pin_sel = instr_ctrl[loop_timer_pkg::PIN_LSB +: loop_timer_pkg::PIN_W];
    assign count_ceiling = CW'(instr_ctrl[loop_timer_pkg::CEIL_LSB +: loop_timer_pkg::CEIL_W]);
    assign cnt_field = compare_word[CW-1:0];
    assign loop_data = compare_word[loop_timer_pkg::LOOP_DATA_LSB +:
        loop_timer_pkg::LOOP_DATA_W];
    assign hires_delay_field = compare_word[loop_timer_pkg::HIRES_DELAY_W-1:0];
    assign reg_val = instr_ctrl[loop_timer_pkg::REGSEL_BIT] ? reg_b_q : reg_a_q;
    // Ordering bit picks at-least or exact equality
    assign match = instr_ctrl[loop_timer_pkg::ORDER_BIT] ? (reg_val >= loop_data)
        : (reg_val == loop_data);
    assign exec_count = (state_q == loop_timer_pkg::ENG_RUN)
        && (opc == loop_timer_pkg::VIRTUAL_COUNT_OP);
    assign exec_cmp = (state_q == loop_timer_pkg::ENG_RUN)
        && (opc == loop_timer_pkg::MAGNITUDE_COMPARE_OP);
    // Ceiling reached last time means this pass restarts at zero
    assign cnt_new = (cnt_field >= count_ceiling) ? '0 : cnt_field + 25'h0000001;

    // Prescaler: master clocks to hires periods to loop periods
    always_comb begin
        hr_tick = (hcnt_q == hr_ratio - 8'h01);
        loop_start = hr_tick && (lcnt_q == lr_ratio - 8'h01);
        hcnt_d = hr_tick ? 8'h00 : hcnt_q + 8'h01;
        lcnt_d = lcnt_q;
        if (hr_tick) begin
            lcnt_d = (lcnt_q == lr_ratio - 8'h01) ? 8'h00 : lcnt_q + 8'h01;
        end
        if (!run_q) begin
            // Held at zero so the first loop is whole
            hcnt_d = 8'h00;
            lcnt_d = 8'h00;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            hcnt_q <= 8'h00;
            lcnt_q <= 8'h00;
        end else begin
            hcnt_q <= hcnt_d;
            lcnt_q <= lcnt_d;
        end
    end

    // Engine sequencing and pin requests
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        slot_d = slot_q;
        reg_a_d = reg_a_q;
        reg_b_d = reg_b_q;
        wrap_d = wrap_q;
        eng_we = 1'b0;
        pe_bus.arm_req = 1'b0;
        pe_bus.clr_req = 1'b0;
        case (state_q)
            loop_timer_pkg::ENG_IDLE: begin
                if (run_q && loop_start) begin
                    state_d = loop_timer_pkg::ENG_RUN;
                    pc_d = '0;
                    slot_d = '0;
                    wrap_d = 1'b0;
                end
            end
            loop_timer_pkg::ENG_RUN: begin
                // No program counter: follow the instruction's own link
                pc_d = next_addr;
                slot_d = slot_q + 15'h0001;
                // Linking back to zero ends the pass; so does the budget
                if (next_addr == '0 || slot_q + 15'h0001 >= timeslot_count || !run_q) begin
                    state_d = loop_timer_pkg::ENG_IDLE;
                end
                if (exec_count) begin
                    eng_we = 1'b1;
                    if (instr_ctrl[loop_timer_pkg::REGSEL_BIT]) begin
                        reg_b_d = cnt_new;
                    end else begin
                        reg_a_d = cnt_new;
                    end
                    if (cnt_field >= count_ceiling) begin
                        wrap_d = 1'b1;
                    end
                end
                if (exec_cmp && pin_en) begin
                    pe_bus.arm_req = match;
                    pe_bus.clr_req = wrap_q;
                end
            end
            default: begin
                state_d = loop_timer_pkg::ENG_IDLE;
            end
        endcase
    end

    // Pin request payload; delay only when high resolution is selected
    assign pe_bus.arm_pin = pin_sel;
    assign pe_bus.clr_pin = pin_sel;
    assign pe_bus.arm_level = pulse_high_action;
    assign pe_bus.clr_level = !pulse_high_action;
    assign pe_bus.arm_delay = resolution_select ?
        valid_delay(hires_delay_field, lr_code_q) : 7'h00;
    assign pe_bus.hr_tick = hr_tick;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_q <= loop_timer_pkg::ENG_IDLE;
            pc_q <= '0;
            slot_q <= '0;
            reg_a_q <= '0;
            reg_b_q <= '0;
            wrap_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            slot_q <= slot_d;
            reg_a_q <= reg_a_d;
            reg_b_q <= reg_b_d;
            wrap_q <= wrap_d;
        end
    end

    // APB slave and program memory; no wait states, read data is registered in the setup cycle
    always_comb begin
        apb_setup = i_psel && !i_penable;
        apb_write = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
        pready_d = apb_setup;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        run_d = run_q;
        hr_code_d = hr_code_q;
        lr_code_d = lr_code_q;
        ram_addr_d = ram_addr_q;
        ram_ctrl_d = ram_ctrl_q;
        ram_data_d = ram_data_q;
        if (apb_setup) begin
            prdata_d = 32'h0000_0000;
            if (i_paddr == loop_timer_pkg::OFF_CTRL) begin
                prdata_d[loop_timer_pkg::CTRL_RUN_BIT] = run_q;
            end else if (i_paddr == loop_timer_pkg::OFF_PRESCALE) begin
                prdata_d[loop_timer_pkg::PRESCALE_HR_LSB +: 3] = hr_code_q;
                prdata_d[loop_timer_pkg::PRESCALE_LR_LSB +: 3] = lr_code_q;
            end else if (i_paddr == loop_timer_pkg::OFF_RAM_ADDR) begin
                prdata_d[AW-1:0] = ram_addr_q;
            end else if (i_paddr == loop_timer_pkg::OFF_RAM_CTRL) begin
                prdata_d = ram_ctrl_q[ram_addr_q];
            end else if (i_paddr == loop_timer_pkg::OFF_RAM_DATA) begin
                prdata_d = ram_data_q[ram_addr_q];
            end else if (i_paddr == loop_timer_pkg::OFF_PINS) begin
                prdata_d[PINS-1:0] = pe_bus.pins;
            end else if (i_paddr == loop_timer_pkg::OFF_REG_A) begin
                prdata_d[CW-1:0] = reg_a_q;
            end else if (i_paddr == loop_timer_pkg::OFF_REG_B) begin
                prdata_d[CW-1:0] = reg_b_q;
            end else begin
                pslverr_d = 1'b1; // Unmapped address
            end
        end
        if (apb_write) begin
            // Host loads the program image through the pointer window
            if (i_paddr == loop_timer_pkg::OFF_CTRL) begin
                run_d = i_pwdata[loop_timer_pkg::CTRL_RUN_BIT];
            end else if (i_paddr == loop_timer_pkg::OFF_PRESCALE) begin
                hr_code_d = i_pwdata[loop_timer_pkg::PRESCALE_HR_LSB +: 3];
                lr_code_d = i_pwdata[loop_timer_pkg::PRESCALE_LR_LSB +: 3];
            end else if (i_paddr == loop_timer_pkg::OFF_RAM_ADDR) begin
                ram_addr_d = i_pwdata[AW-1:0];
            end else if (i_paddr == loop_timer_pkg::OFF_RAM_CTRL) begin
                ram_ctrl_d[ram_addr_q] = i_pwdata;
            end else if (i_paddr == loop_timer_pkg::OFF_RAM_DATA) begin
                ram_data_d[ram_addr_q] = i_pwdata;
            end
        end
        // Counter write-back wins over a host write to the same word
        if (eng_we) begin
            ram_data_d[pc_q] = {compare_word[31:CW], cnt_new};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            run_q <= 1'b0;
            hr_code_q <= loop_timer_pkg::RESET_HR_CODE;
            lr_code_q <= loop_timer_pkg::RESET_LR_CODE;
            ram_addr_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                ram_ctrl_q[i] <= 32'h0000_0000;
                ram_data_q[i] <= 32'h0000_0000;
            end
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            run_q <= run_d;
            hr_code_q <= hr_code_d;
            lr_code_q <= lr_code_d;
            ram_addr_q <= ram_addr_d;
            ram_ctrl_q <= ram_ctrl_d;
            ram_data_q <= ram_data_d;
        end
    end

    pin_edge_unit #(.PINS(PINS)) u_pin_edge (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .pe(pe_bus)
    );

    assign o_pin_out = pe_bus.pins;
    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;

    // Helper: clocks since the last loop start, for the period check
    logic [15:0] gap_q;
    logic seen_q;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !run_q) begin
            gap_q <= 16'h0000;
            seen_q <= 1'b0;
        end else begin
            gap_q <= loop_start ? 16'h0000 : gap_q + 16'h0001;
            seen_q <= seen_q || loop_start;
        end
    end

    a_loop_period_len:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (loop_start && seen_q && $stable(hr_code_q) && $stable(lr_code_q))
        |-> 16'(gap_q + 16'h0001) == 16'(timeslot_count))
    else $error("loop period differs from loop ratio times high-res ratio");

    a_full_rate_tick:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (run_q && hr_code_q == 3'h0) |-> hr_tick)
    else $error("ratio one did not tick every clock");

    a_count_step:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (exec_count && cnt_field < count_ceiling && !instr_ctrl[loop_timer_pkg::REGSEL_BIT])
        |=> reg_a_q == $past(cnt_field) + 25'h0000001)
    else $error("counter did not add one into register");

    a_count_wrap_zero:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (exec_count && cnt_field >= count_ceiling)
        |=> wrap_q && ram_data_q[$past(pc_q)][CW-1:0] == '0)
    else $error("counter did not return to zero with wrap flag");

    a_next_link:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state_q == loop_timer_pkg::ENG_RUN) |=> pc_q == $past(next_addr))
    else $error("engine did not follow next address");

    a_match_arms_pin:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (exec_cmp && pin_en && instr_ctrl[loop_timer_pkg::ORDER_BIT] && reg_val >= loop_data)
        |-> pe_bus.arm_req && pe_bus.arm_pin == pin_sel)
    else $error("match did not request pin action");

    a_wrap_clears_pin:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (exec_cmp && pin_en && wrap_q && pulse_high_action)
        |-> pe_bus.clr_req && !pe_bus.clr_level)
    else $error("pulse high did not clear pin on wrap");
endmodule
`default_nettype wire

// File: verification/pwm_load_model.sv
// Purpose: External load on one PWM pin, measures period and high time
// Assumes: Pin level is sampled on the system clock rising edge
// Notes: Values are in clocks and update at each rising or falling edge
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
    input wire logic i_clk,
    input wire logic i_pin,
    output int o_period,
    output int o_high
);
    int since_rise; // Clocks since the last rising edge
    logic last_q; // Previous pin level
    initial begin
        since_rise = 0;
        last_q = 1'b0;
        o_period = 0;
        o_high = 0;
    end
    // Edge timing capture; the first period after start is partial
    always @(posedge i_clk) begin
        if (i_pin === 1'b1 && last_q === 1'b0) begin
            o_period <= since_rise;
            since_rise <= 1;
        end else begin
            since_rise <= since_rise + 1;
        end
        if (i_pin === 1'b0 && last_q === 1'b1) begin
            o_high <= since_rise;
        end
        last_q <= i_pin;
    end
endmodule
`default_nettype wire

// File: verification/loop_timer_pwm_engine_tb.sv
// Purpose: Self-checking bench for the loop timer PWM engine
// Assumes: APB access with no wait states, pin zero carries the PWM
// Notes: Program is a counter plus one compare, two timeslots of eight
`timescale 1ns/1ps
`default_nettype none
module loop_timer_pwm_engine_tb;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic [7:0] o_pin_out;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int period;
    int high;
    int high_hr; // High time with the sub-loop delay applied
    logic [31:0] rd; // Last read data
    logic err; // Last slave error
    loop_timer_pwm_engine uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_pin_out(o_pin_out));
    pwm_load_model load (.i_clk(i_clk_sys), .i_pin(o_pin_out[0]), .o_period(period),
        .o_high(high));
    always #2.5 i_clk_sys = ~i_clk_sys;
    // Hang guard, well above the under two thousand clocks the tests need
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    // Load one instruction: control word and data word at a RAM slot
    task automatic load_word(input logic [3:0] slot, input logic [31:0] c, input logic [31:0] d);
        apb(1'b1, loop_timer_pkg::OFF_RAM_ADDR, {28'h0, slot});
        apb(1'b1, loop_timer_pkg::OFF_RAM_CTRL, c);
        apb(1'b1, loop_timer_pkg::OFF_RAM_DATA, d);
    endtask
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        // Reset prescale: hires ratio 1, loop ratio 8
        apb(1'b0, loop_timer_pkg::OFF_PRESCALE, 32'h0);
        check("prescale", rd, 32'h00000300);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        $display("test registers done");
        // Counter ceiling 9, compare 6 with delay field 0x60 (valid bits give 6)
        load_word(4'h0, 32'h00090011, 32'h0);
        load_word(4'h1, 32'h000007a0, 32'h00000360);
        apb(1'b0, loop_timer_pkg::OFF_RAM_CTRL, 32'h0);
        check("ram readback", rd, 32'h000007a0);
        apb(1'b1, loop_timer_pkg::OFF_CTRL, 32'h1);
        repeat (500) @(posedge i_clk_sys);
        check("pwm period", period, 32'd80);
        check("other pins", {25'h0, o_pin_out[7:1]}, 32'h0);
        apb(1'b0, loop_timer_pkg::OFF_REG_A, 32'h0);
        check("count range", {31'h0, rd <= 32'd9}, 32'h1);
        high_hr = high;
        $display("test hires pwm done");
        // Same compare without high resolution: edge moves six clocks earlier
        load_word(4'h1, 32'h000006a0, 32'h00000360);
        repeat (500) @(posedge i_clk_sys);
        check("delay effect", high - high_hr, 32'd6);
        check("loop period", period, 32'd80);
        $display("test loop pwm done");
        // High-res ratio two doubles each loop; run off first so the prescaler restarts whole
        apb(1'b1, loop_timer_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, loop_timer_pkg::OFF_PRESCALE, 32'h00000301);
        apb(1'b1, loop_timer_pkg::OFF_CTRL, 32'h1);
        repeat (700) @(posedge i_clk_sys);
        check("slow period", period, 32'd160);
        check("slow high", high, 32'd63);
        $display("test hires ratio two done");
        summarize();
    end
endmodule
`default_nettype wire
